// ### logic/spmg_guard.sv
// self-programming mode guard: protected mode control, status flags, halt timing
// Behaviour
// - protect setting is fetched from flash byte 0081H.
// - mode control changes only after key, value, inverse, value stores.
// - second and third stores leave mode control untouched; fourth takes effect.
// - enable 0 makes halt enter standby; enable 1 makes halt launch flash, except the first halt after entry.
// - reset release clears enable and loads protect setting into bits 2..6.
// - protect setting bits are read-only.
// - halt after mode entry is released within 10 us plus 2 clocks.
// - a write without proper unlock is dropped and sets sequence error.
// - sequence error clears by writing 0 and on reset.
// - verify and protect error flags clear by writing 0.
// - reset clears the whole status register.
// - a store elsewhere mid-sequence sets sequence error.
// - wrong inverse or wrong repeated value sets sequence error.
// - key write out of sequence position sets sequence error.
// - verify failures of erase or write set verify error.
// - other mode control and key contents carry no reset meaning.
// - protected-area command or 0-to-1 write sets protect error.
`timescale 1ns/10ps
`default_nettype none
module spmg_guard
  import spmg_pkg::*;
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // peripheral bus
  input wire logic BUS_WR_IN,
  input wire logic BUS_RD_IN,
  input wire logic [15:0] BUS_ADDR_IN,
  input wire logic [7:0] BUS_WDATA_IN,
  output logic [7:0] BUS_RDATA_OUT,
  // protect byte fetch
  input wire logic [4:0] PROTECT_BYTE_IN,
  output logic [15:0] PROTECT_BYTE_ADDR_OUT,
  // cpu halt handling
  input wire logic HALT_IN,
  output logic STANDBY_REQ_OUT,
  output logic HALT_RELEASE_OUT,
  // flash sequencer
  output logic FLASH_START_OUT,
  input wire logic FLASH_DONE_IN,
  input wire logic VERIFY_FAIL_IN,
  input wire logic PROTECT_FAIL_IN,
  // mode view
  output logic SELF_PROG_MODE_OUT,
  output logic [4:0] PROTECT_SETTING_OUT
);

  // ****************************************
  // state
  // ****************************************
  spmg_store_if st ();
  logic self_prog_enable_reg;
  logic [4:0] protect_setting_reg;
  logic protect_load_pending_reg;
  logic entry_pending_reg;
  logic sequence_error_flag_reg;
  logic verify_error_flag_reg;
  logic write_erase_protect_error_flag_reg;
  logic [8:0] entry_cnt_reg;
  spmg_halt_e halt_state_reg;
  logic status_write;
  logic halt_accept;

  function automatic logic clear_by_zero(input logic flag, input logic wr, input logic bitval);
    clear_by_zero = flag && !(wr && !bitval);
  endfunction : clear_by_zero

  assign st.store = BUS_WR_IN;
  assign st.addr = BUS_ADDR_IN;
  assign st.data = BUS_WDATA_IN;
  assign status_write = BUS_WR_IN && BUS_ADDR_IN == PROGRAM_STATUS_ADDR;
  assign halt_accept = HALT_IN && halt_state_reg == SPMG_RUN && !protect_load_pending_reg;

  spmg_unlock_seq u_seq (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .st(st)
  );

  // ****************************************
  // protect byte reload after reset
  // ****************************************
  // the fetch address is static; the byte is sampled on the first edge after release
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      PROTECT_BYTE_ADDR_OUT <= PROTECT_BYTE_FLASH_ADDR;
      protect_load_pending_reg <= 1'b1;
      protect_setting_reg <= PROTECT_SETTING_RESET;
    end else begin
      PROTECT_BYTE_ADDR_OUT <= PROTECT_BYTE_FLASH_ADDR;
      if (protect_load_pending_reg) begin
        protect_setting_reg <= PROTECT_BYTE_IN;
        protect_load_pending_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // mode control
  // ****************************************
  // only the unlock commit reaches this bit; protect bits are never written by software
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      self_prog_enable_reg <= 1'b0;
      entry_pending_reg <= 1'b0;
    end else begin
      if (st.commit) begin
        self_prog_enable_reg <= st.commit_value[SELF_PROG_ENABLE_POS];
      end
      if (st.commit && st.commit_value[SELF_PROG_ENABLE_POS] && !self_prog_enable_reg) begin
        entry_pending_reg <= 1'b1;
      end else if (halt_accept || (st.commit && !st.commit_value[SELF_PROG_ENABLE_POS])) begin
        entry_pending_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  // a hardware set in the same cycle as a clear by zero wins
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sequence_error_flag_reg <= PROGRAM_STATUS_RESET[SEQUENCE_ERROR_POS];
    end else begin
      sequence_error_flag_reg <= st.seq_error ||
        clear_by_zero(sequence_error_flag_reg, status_write,
                      BUS_WDATA_IN[SEQUENCE_ERROR_POS]);
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      verify_error_flag_reg <= PROGRAM_STATUS_RESET[VERIFY_ERROR_POS];
    end else begin
      verify_error_flag_reg <= VERIFY_FAIL_IN ||
        clear_by_zero(verify_error_flag_reg, status_write,
                      BUS_WDATA_IN[VERIFY_ERROR_POS]);
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      write_erase_protect_error_flag_reg <=
        PROGRAM_STATUS_RESET[WRITE_ERASE_PROTECT_ERROR_POS];
    end else begin
      write_erase_protect_error_flag_reg <= PROTECT_FAIL_IN ||
        clear_by_zero(write_erase_protect_error_flag_reg, status_write,
                      BUS_WDATA_IN[WRITE_ERASE_PROTECT_ERROR_POS]);
    end
  end

  // ****************************************
  // halt handling
  // ****************************************
  // halts are ignored during the one-cycle protect reload and while a release is pending
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      halt_state_reg <= SPMG_RUN;
      entry_cnt_reg <= 9'h000;
      STANDBY_REQ_OUT <= 1'b0;
      FLASH_START_OUT <= 1'b0;
      HALT_RELEASE_OUT <= 1'b0;
    end else begin
      STANDBY_REQ_OUT <= 1'b0;
      FLASH_START_OUT <= 1'b0;
      HALT_RELEASE_OUT <= 1'b0;
      unique case (halt_state_reg)
        SPMG_RUN: begin
          if (halt_accept) begin
            if (!self_prog_enable_reg) begin
              STANDBY_REQ_OUT <= 1'b1;
            end else if (entry_pending_reg) begin
              entry_cnt_reg <= ENTRY_RELEASE_LOAD;
              halt_state_reg <= SPMG_ENTRY_WAIT;
            end else begin
              FLASH_START_OUT <= 1'b1;
              halt_state_reg <= SPMG_FLASH_BUSY;
            end
          end
        end
        SPMG_ENTRY_WAIT: begin
          if (entry_cnt_reg == 9'h000) begin
            HALT_RELEASE_OUT <= 1'b1;
            halt_state_reg <= SPMG_RUN;
          end else begin
            entry_cnt_reg <= entry_cnt_reg - 9'h001;
          end
        end
        SPMG_FLASH_BUSY: begin
          if (FLASH_DONE_IN) begin
            HALT_RELEASE_OUT <= 1'b1;
            halt_state_reg <= SPMG_RUN;
          end
        end
        // unused fourth code falls back to run so the halt handler cannot stick there
        default: begin
          halt_state_reg <= SPMG_RUN;
        end
      endcase
    end
  end

  // ****************************************
  // read port and mode view
  // ****************************************
  // key register is write-only and reads zero; read data follows the strobe by one cycle
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      BUS_RDATA_OUT <= 8'h00;
      SELF_PROG_MODE_OUT <= 1'b0;
      PROTECT_SETTING_OUT <= PROTECT_SETTING_RESET;
    end else begin
      SELF_PROG_MODE_OUT <= self_prog_enable_reg;
      PROTECT_SETTING_OUT <= protect_setting_reg;
      BUS_RDATA_OUT <= 8'h00;
      if (BUS_RD_IN && BUS_ADDR_IN == PROGRAM_STATUS_ADDR) begin
        BUS_RDATA_OUT <= {5'h00, write_erase_protect_error_flag_reg,
                          verify_error_flag_reg, sequence_error_flag_reg};
      end else if (BUS_RD_IN && BUS_ADDR_IN == PROGRAM_MODE_CONTROL_ADDR) begin
        BUS_RDATA_OUT <= {1'b0, protect_setting_reg, 1'b0, self_prog_enable_reg};
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_entry_halt;
    HALT_IN && halt_state_reg == SPMG_RUN && !protect_load_pending_reg &&
      self_prog_enable_reg && entry_pending_reg;
  endsequence

  sequence s_entry_release;
    !HALT_RELEASE_OUT [*8] ##245 HALT_RELEASE_OUT;
  endsequence

  property p_entry_release_time;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    s_entry_halt |=> s_entry_release;
  endproperty
  a_entry_release_time: assert property (p_entry_release_time)
    else $error("entry halt not released after 252 cycles");

  property p_normal_halt_standby;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    halt_accept && !self_prog_enable_reg |=> STANDBY_REQ_OUT && !FLASH_START_OUT;
  endproperty
  a_normal_halt_standby: assert property (p_normal_halt_standby)
    else $error("normal-mode halt did not request standby");

  property p_prog_halt_launch;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    halt_accept && self_prog_enable_reg && !entry_pending_reg
      |=> FLASH_START_OUT && !STANDBY_REQ_OUT;
  endproperty
  a_prog_halt_launch: assert property (p_prog_halt_launch)
    else $error("self-program halt did not launch flash");

  property p_mode_changes_only_on_commit;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    !$stable(self_prog_enable_reg) |-> $past(st.commit);
  endproperty
  a_mode_changes_only_on_commit: assert property (p_mode_changes_only_on_commit)
    else $error("mode bit changed without unlock commit");

  property p_protect_bits_hold;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    !protect_load_pending_reg |=> $stable(protect_setting_reg);
  endproperty
  a_protect_bits_hold: assert property (p_protect_bits_hold)
    else $error("protect setting changed after reload");

  property p_protect_load;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    protect_load_pending_reg |=> protect_setting_reg == $past(PROTECT_BYTE_IN)
      ##1 PROTECT_SETTING_OUT == protect_setting_reg;
  endproperty
  a_protect_load: assert property (p_protect_load)
    else $error("protect byte not loaded after reset");

  property p_seq_error_sets;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    st.seq_error |=> sequence_error_flag_reg;
  endproperty
  a_seq_error_sets: assert property (p_seq_error_sets)
    else $error("sequence error not recorded");

  property p_seq_flag_clear;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    status_write && !BUS_WDATA_IN[SEQUENCE_ERROR_POS] && !st.seq_error
      |=> !sequence_error_flag_reg;
  endproperty
  a_seq_flag_clear: assert property (p_seq_flag_clear)
    else $error("sequence error not cleared by zero write");

  property p_verify_flag;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    VERIFY_FAIL_IN |=> verify_error_flag_reg;
  endproperty
  a_verify_flag: assert property (p_verify_flag)
    else $error("verify failure not recorded");

  property p_protect_flag_clear;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    PROTECT_FAIL_IN ##1 (status_write && !BUS_WDATA_IN[WRITE_ERASE_PROTECT_ERROR_POS]
      && !PROTECT_FAIL_IN) |=> !write_erase_protect_error_flag_reg;
  endproperty
  a_protect_flag_clear: assert property (p_protect_flag_clear)
    else $error("protect error flag not cleared by zero write");

  property p_flash_done_release;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    halt_state_reg == SPMG_FLASH_BUSY && FLASH_DONE_IN |=> HALT_RELEASE_OUT;
  endproperty
  a_flash_done_release: assert property (p_flash_done_release)
    else $error("flash completion did not release halt");

  property p_entry_release_not_early;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    halt_state_reg == SPMG_ENTRY_WAIT && entry_cnt_reg != 9'h000 |=> !HALT_RELEASE_OUT;
  endproperty
  a_entry_release_not_early: assert property (p_entry_release_not_early)
    else $error("entry halt released before count ran out");

  property p_protect_flag_sets;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    PROTECT_FAIL_IN |=> write_erase_protect_error_flag_reg;
  endproperty
  a_protect_flag_sets: assert property (p_protect_flag_sets)
    else $error("protect failure not recorded");

  property p_busy_halt_ignored;
    @(posedge CLK_IN) disable iff (!RST_N_IN)
    halt_state_reg != SPMG_RUN |=> !STANDBY_REQ_OUT && !FLASH_START_OUT;
  endproperty
  a_busy_halt_ignored: assert property (p_busy_halt_ignored)
    else $error("halt acted on while a release was pending");

endmodule : spmg_guard
`default_nettype wire

// ### logic/spmg_pkg.sv
// constants and types shared by the self-programming mode guard
package spmg_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] UNLOCK_KEY_ADDR = 16'hFFA0;
  localparam logic [15:0] PROGRAM_STATUS_ADDR = 16'hFFA1;
  localparam logic [15:0] PROGRAM_MODE_CONTROL_ADDR = 16'hFFA2;

  // ****************************************
  // field positions and values
  // ****************************************
  localparam logic [7:0] UNLOCK_KEY_VALUE = 8'hA5;
  localparam int SELF_PROG_ENABLE_POS = 0;
  localparam int PROTECT_SETTING_LSB = 2;
  localparam int PROTECT_SETTING_MSB = 6;
  localparam int SEQUENCE_ERROR_POS = 0;
  localparam int VERIFY_ERROR_POS = 1;
  localparam int WRITE_ERASE_PROTECT_ERROR_POS = 2;
  localparam logic [2:0] PROGRAM_STATUS_RESET = 3'h0;
  localparam logic [4:0] PROTECT_SETTING_RESET = 5'h00;
  localparam logic [15:0] PROTECT_BYTE_FLASH_ADDR = 16'h0081;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_FREQ_KHZ = 25000;
  localparam int ENTRY_RELEASE_MAX_US = 10;
  localparam int ENTRY_RELEASE_EXTRA_CLKS = 2;
  // longest time: rounded down
  localparam int ENTRY_RELEASE_CYC =
    (ENTRY_RELEASE_MAX_US * CLK_FREQ_KHZ) / 1000 + ENTRY_RELEASE_EXTRA_CLKS;
  localparam logic [8:0] ENTRY_RELEASE_LOAD = 9'(ENTRY_RELEASE_CYC - 1);

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SPMG_UNLOCK_IDLE,
    SPMG_UNLOCK_GOT_KEY,
    SPMG_UNLOCK_GOT_VALUE,
    SPMG_UNLOCK_GOT_INVERSE
  } spmg_unlock_e;

  typedef enum logic [1:0] {
    SPMG_RUN,
    SPMG_ENTRY_WAIT,
    SPMG_FLASH_BUSY
  } spmg_halt_e;

endpackage : spmg_pkg

// ### logic/spmg_store_if.sv
// peripheral store events and unlock verdicts between guard and sequencer
`timescale 1ns/10ps
`default_nettype none
interface spmg_store_if;
  logic store;
  logic [15:0] addr;
  logic [7:0] data;
  logic commit;
  logic [7:0] commit_value;
  logic seq_error;

  modport guard (output store, output addr, output data,
                 input commit, input commit_value, input seq_error);
  modport seq (input store, input addr, input data,
               output commit, output commit_value, output seq_error);
endinterface : spmg_store_if
`default_nettype wire

// ### logic/spmg_unlock_seq.sv
// unlock sequence tracker guarding the mode-control register
`timescale 1ns/10ps
`default_nettype none
module spmg_unlock_seq
  import spmg_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  spmg_store_if.seq st
);

  spmg_unlock_e state_reg;
  logic [7:0] value_reg;
  logic to_mode;
  logic to_key;

  assign to_mode = st.addr == PROGRAM_MODE_CONTROL_ADDR;
  assign to_key = st.addr == UNLOCK_KEY_ADDR;

  // ****************************************
  // sequence tracking
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= SPMG_UNLOCK_IDLE;
      value_reg <= 8'h00;
      st.commit <= 1'b0;
      st.commit_value <= 8'h00;
      st.seq_error <= 1'b0;
    end else begin
      st.commit <= 1'b0;
      st.seq_error <= 1'b0;
      if (st.store) begin
        state_reg <= SPMG_UNLOCK_IDLE;
        unique case (state_reg)
          SPMG_UNLOCK_IDLE: begin
            if (to_key && st.data == UNLOCK_KEY_VALUE) begin
              state_reg <= SPMG_UNLOCK_GOT_KEY;
            end else if (to_mode) begin
              st.seq_error <= 1'b1;
            end
          end
          SPMG_UNLOCK_GOT_KEY: begin
            if (to_mode) begin
              value_reg <= st.data;
              state_reg <= SPMG_UNLOCK_GOT_VALUE;
            end else begin
              st.seq_error <= 1'b1;
            end
          end
          SPMG_UNLOCK_GOT_VALUE: begin
            if (to_mode && st.data == ~value_reg) begin
              state_reg <= SPMG_UNLOCK_GOT_INVERSE;
            end else begin
              st.seq_error <= 1'b1;
            end
          end
          SPMG_UNLOCK_GOT_INVERSE: begin
            if (to_mode && st.data == value_reg) begin
              st.commit <= 1'b1;
              st.commit_value <= value_reg;
            end else begin
              st.seq_error <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_commit_needs_full_sequence;
    @(posedge clk_in) disable iff (!rst_n_in)
    st.commit |-> $past(state_reg) == SPMG_UNLOCK_GOT_INVERSE && $past(st.store);
  endproperty
  a_commit_needs_full_sequence: assert property (p_commit_needs_full_sequence)
    else $error("mode commit without complete unlock sequence");

  property p_error_returns_idle;
    @(posedge clk_in) disable iff (!rst_n_in)
    st.seq_error |-> state_reg == SPMG_UNLOCK_IDLE;
  endproperty
  a_error_returns_idle: assert property (p_error_returns_idle)
    else $error("unlock tracker not idle after sequence error");

  property p_bad_inverse_errors;
    @(posedge clk_in) disable iff (!rst_n_in)
    st.store && state_reg == SPMG_UNLOCK_GOT_VALUE && to_mode && st.data != ~value_reg
      |=> st.seq_error && !st.commit;
  endproperty
  a_bad_inverse_errors: assert property (p_bad_inverse_errors)
    else $error("wrong inverse store not flagged");

endmodule : spmg_unlock_seq
`default_nettype wire

// ### verification/tb.sv
// self-checking testbench for the self-programming mode guard
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp); \
    end \
  end
module tb;
  import spmg_pkg::*;
  localparam logic [15:0] A_KEY = UNLOCK_KEY_ADDR;
  localparam logic [15:0] A_STS = PROGRAM_STATUS_ADDR;
  localparam logic [15:0] A_MODE = PROGRAM_MODE_CONTROL_ADDR;
  localparam logic [23:0] KEYS = {UNLOCK_KEY_ADDR, UNLOCK_KEY_VALUE};
  // ****************
  // stimulus and observation
  // ****************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [15:0] bus_addr = 16'h0000;
  logic [7:0] bus_wdata = 8'h00;
  logic [4:0] prot_byte = 5'h15;
  logic halt = 1'b0;
  logic flash_done = 1'b0;
  logic verify_fail = 1'b0;
  logic protect_fail = 1'b0;
  logic [7:0] bus_rdata;
  logic [15:0] prot_addr;
  logic standby_req, halt_release, flash_start, self_prog_mode;
  logic [4:0] prot_setting;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [31:0] rng = 32'h5165;
  logic [7:0] st_exp = 8'h00;
  logic [4:0] prot_exp;
  logic [7:0] v;
  int n;

  always #20 clk = ~clk;

  spmg_guard dut (
    .CLK_IN(clk), .RST_N_IN(rst_n), .BUS_WR_IN(bus_wr), .BUS_RD_IN(bus_rd),
    .BUS_ADDR_IN(bus_addr), .BUS_WDATA_IN(bus_wdata), .BUS_RDATA_OUT(bus_rdata),
    .PROTECT_BYTE_IN(prot_byte), .PROTECT_BYTE_ADDR_OUT(prot_addr), .HALT_IN(halt),
    .STANDBY_REQ_OUT(standby_req), .HALT_RELEASE_OUT(halt_release),
    .FLASH_START_OUT(flash_start), .FLASH_DONE_IN(flash_done),
    .VERIFY_FAIL_IN(verify_fail), .PROTECT_FAIL_IN(protect_fail),
    .SELF_PROG_MODE_OUT(self_prog_mode), .PROTECT_SETTING_OUT(prot_setting)
  );

  // ****************
  // expectation helpers
  // ****************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  function automatic logic [7:0] mode_exp(input logic en, input logic [4:0] p);
    return {1'b0, p, 1'b0, en};
  endfunction : mode_exp

  // a written 1 keeps a flag, a written 0 clears it
  function automatic logic [7:0] st_write(input logic [7:0] s, input logic [7:0] w);
    return {5'h00, s[2:0] & w[2:0]};
  endfunction : st_write

  // ****************
  // bus and halt tasks
  // ****************
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  // back-to-back stores, strobe held high across them
  task automatic burst(input logic [23:0] s [4], input int cnt);
    @(posedge clk);
    bus_wr <= 1'b1;
    for (int i = 0; i < cnt; i++) begin
      {bus_addr, bus_wdata} <= s[i];
      @(posedge clk);
    end
    bus_wr <= 1'b0;
    @(posedge clk);
  endtask : burst

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    `CHK(bus_rdata, e, "read")
  endtask : rd

  task automatic halt_pulse();
    @(posedge clk);
    halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    #1;
  endtask : halt_pulse

  task automatic run_err(input logic [23:0] s [4], input int cnt);
    burst(s, cnt);
    rd(A_STS, 8'h01);
    rd(A_MODE, mode_exp(1'b0, prot_exp));
    wr(A_STS, 8'h00);
    rd(A_STS, 8'h00);
  endtask : run_err

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    prot_exp = prot_byte;
    `CHK(prot_addr, PROTECT_BYTE_FLASH_ADDR, "paddr")
    rd(A_STS, 8'h00);
    rd(A_MODE, mode_exp(1'b0, prot_exp));
    `CHK(prot_setting, prot_exp, "prot")
    rd(A_KEY, 8'h00);
    halt_pulse();
    `CHK(standby_req, 1'b1, "standby")
    `CHK(flash_start, 1'b0, "start")
    rng = xs(rng);
    run_err('{{A_MODE, 8'h01}, 24'h0, 24'h0, 24'h0}, 1);
    run_err('{KEYS, {16'hFFA3, rng[7:0]}, 24'h0, 24'h0}, 2);
    run_err('{KEYS, {A_MODE, 8'h01}, {16'hFFA4, rng[15:8]}, 24'h0}, 3);
    run_err('{KEYS, {A_MODE, 8'h01}, {A_MODE, 8'hFE}, {16'hFFA3, 8'h00}}, 4);
    run_err('{KEYS, {A_MODE, 8'h01}, {A_MODE, 8'h01}, 24'h0}, 3);
    run_err('{KEYS, {A_MODE, 8'h01}, {A_MODE, 8'hFE}, {A_MODE, 8'h00}}, 4);
    run_err('{KEYS, {A_MODE, 8'h01}, KEYS, 24'h0}, 3);
    run_err('{{A_MODE, 8'h01}, 24'h0, 24'h0, 24'h0}, 1);
    // stepwise entry with random read-only bits in the value
    rng = xs(rng);
    v = rng[7:0] | 8'h01;
    // no flash command and no interrupt is ever live around a mode change
    wr(A_KEY, UNLOCK_KEY_VALUE);
    wr(A_MODE, v);
    rd(A_MODE, mode_exp(1'b0, prot_exp));
    wr(A_MODE, ~v);
    rd(A_MODE, mode_exp(1'b0, prot_exp));
    wr(A_MODE, v);
    rd(A_MODE, mode_exp(1'b1, prot_exp));
    `CHK(self_prog_mode, 1'b1, "mode")
    rd(A_STS, 8'h00);
    halt_pulse();
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (halt_release !== 1'b1 && n < 400);
    `CHK(n, ENTRY_RELEASE_CYC, "entry release")
    // settle time needed when the system clock is a crystal or external one
    repeat (200) @(posedge clk);
    wr(A_STS, 8'h00);
    halt_pulse();
    `CHK(flash_start, 1'b1, "start")
    `CHK(standby_req, 1'b0, "standby")
    repeat (5) @(posedge clk);
    #1;
    `CHK(halt_release, 1'b0, "early release")
    @(posedge clk);
    flash_done <= 1'b1;
    verify_fail <= 1'b1;
    @(posedge clk);
    flash_done <= 1'b0;
    verify_fail <= 1'b0;
    #1;
    `CHK(halt_release, 1'b1, "flash release")
    rd(A_STS, 8'h02);
    wr(A_STS, 8'h00);
    rd(A_STS, 8'h00);
    // exit with back-to-back stores
    v = rng[15:8] & 8'hFE;
    burst('{KEYS, {A_MODE, v}, {A_MODE, ~v}, {A_MODE, v}}, 4);
    rd(A_MODE, mode_exp(1'b0, prot_exp));
    halt_pulse();
    `CHK(standby_req, 1'b1, "standby")
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      @(posedge clk);
      verify_fail <= rng[0];
      protect_fail <= rng[1];
      @(posedge clk);
      verify_fail <= 1'b0;
      protect_fail <= 1'b0;
      st_exp[1] = st_exp[1] | rng[0];
      st_exp[2] = st_exp[2] | rng[1];
      rd(A_STS, st_exp);
      wr(A_STS, rng[15:8]);
      st_exp = st_write(st_exp, rng[15:8]);
      rd(A_STS, st_exp);
    end
    // fast re-entry, then reset in self-programming mode with a flag set
    burst('{KEYS, {A_MODE, 8'h01}, {A_MODE, 8'hFE}, {A_MODE, 8'h01}}, 4);
    @(posedge clk);
    #1;
    `CHK(self_prog_mode, 1'b1, "mode")
    @(posedge clk);
    protect_fail <= 1'b1;
    @(posedge clk);
    protect_fail <= 1'b0;
    prot_byte <= rng[20:16];
    prot_exp = rng[20:16];
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(A_STS, 8'h00);
    rd(A_MODE, mode_exp(1'b0, prot_exp));
    `CHK(self_prog_mode, 1'b0, "mode")
    conclude();
  end

  // run needs about 700 cycles; over eight times that means a hang
  initial begin
    #(40 * 6000);
    n_mismatch++;
    conclude();
  end
endmodule : tb
`undef CHK
`default_nettype wire
